// [design/aeta_defines.svh]
// Constants for the architected activity event type register bank.
// Assumes it is included by bare name from the design modules.
// How it works
// - Low word matches on external view
// - Upper bits zero, low sixteen hold event
// - Counter 0 returns processor cycles event
// - Counter 1 returns constant frequency event
// - Counter 2 returns instructions retired event
// - Index at or above counter count undefined
// - Group 0 counter count reports four
// - Decode fixed encoding, op2 selects index
// - Halted, secure debug off, level-3 trap: undefined first
// - Level 0 user enable clear traps
// - Level-2 monitor trap bit traps to level 2
// - Level-3 monitor trap bit traps to level 3
// - Level 2 applies only level-3 checks
// - Level 3 always reads value
`ifndef AETA_DEFINES_SVH
`define AETA_DEFINES_SVH

// System-register encoding of the event type group
`define AETA_OP0          2'h3
`define AETA_OP1          3'h3
`define AETA_CRN          4'hd
`define AETA_CRM          4'h6

// Fixed event numbers per architected counter
`define AETA_EVT_0        16'h0011
`define AETA_EVT_1        16'h1004
`define AETA_EVT_2        16'h0000

// Layout
`define AETA_REG_W        64
`define AETA_FIELD_W      16
`define AETA_EXT_W        32
`define AETA_UPPER_W      48
`define AETA_NUM_REGS     3'h3
`define AETA_REG_IDX_W    2

// Counter group 0 size and trap class
`define AETA_CG0_COUNT    8'h04
`define AETA_IDX_PAD      5'h00
`define AETA_TRAP_CLASS   6'h18
`define AETA_NO_CLASS     6'h00

`endif

// [design/aeta_pkg.sv]
// Types for the architected activity event type register bank.
// Enum codes are written as literals; nothing is taken from aeta_defines.svh.
package aeta_pkg;

  // Exception level of the issuing instruction
  typedef enum logic [1:0] {
    AETA_EL0 = 2'h0,
    AETA_EL1 = 2'h1,
    AETA_EL2 = 2'h2,
    AETA_EL3 = 2'h3
  } aeta_el_t;

  // Request sequencer, Gray coded along idle, check, answer
  typedef enum logic [1:0] {
    AETA_IDLE  = 2'h0,
    AETA_CHECK = 2'h1,
    AETA_RESP  = 2'h3
  } aeta_state_t;

endpackage

// [design/aeta_event_reg.sv]
// One read-only event type register holding a fixed event number.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "aeta_defines.svh"
module aeta_event_reg #(
  parameter logic [15:0] EVENT = 16'h0000
) (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // Register contents
  output logic [63:0]      value
);

  logic [15:0] event_number_field;  // Held event number
  logic [15:0] next_event_number_field;

  // Hold the mandated number; no write path exists
  always_comb begin
    next_event_number_field = event_number_field;
  end

  // Reset loads the constant so reads are never unknown
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      event_number_field <= EVENT;
    end else begin
      event_number_field <= next_event_number_field;
    end
  end

  // Reserved upper bits read as zero
  assign value = {{`AETA_UPPER_W{1'b0}}, event_number_field};

endmodule

// [design/aeta_access_check.sv]
// Privilege checks for a read of an activity monitor event type register.
// Assumes all inputs are stable for the cycle they are evaluated in.
`timescale 1ns/1ps
`include "aeta_defines.svh"
module aeta_access_check (
  // Execution context
  input  wire logic [1:0]  level,
  input  wire logic        halted,
  input  wire logic        secure_debug_disabled,
  input  wire logic        el2_enabled,
  // Trap controls
  input  wire logic        user_access_enable,
  input  wire logic        host_trap_general,
  input  wire logic        level2_monitor_trap,
  input  wire logic        level3_monitor_trap,
  // Outcome
  output logic             undefined,
  output logic             trap,
  output logic [1:0]       trap_level
);

  logic locked_debug;  // Halted with secure debug off

  assign locked_debug = halted && secure_debug_disabled;

  // Priority chain, earliest check wins
  always_comb begin
    undefined  = 1'b0;
    trap       = 1'b0;
    trap_level = aeta_pkg::AETA_EL1;
    if (level == aeta_pkg::AETA_EL3) begin
      // Highest level reads unconditionally
      undefined = 1'b0;
    end else if (locked_debug && level3_monitor_trap) begin
      undefined = 1'b1;
    end else if (level == aeta_pkg::AETA_EL0 && !user_access_enable) begin
      trap       = 1'b1;
      trap_level = (el2_enabled && host_trap_general) ? aeta_pkg::AETA_EL2
                                                      : aeta_pkg::AETA_EL1;
    end else if (level != aeta_pkg::AETA_EL2 && el2_enabled && level2_monitor_trap) begin
      // Level 2 skips this and the user check
      trap       = 1'b1;
      trap_level = aeta_pkg::AETA_EL2;
    end else if (level3_monitor_trap) begin
      // Already excluded the locked-debug case above
      trap       = 1'b1;
      trap_level = aeta_pkg::AETA_EL3;
    end
  end

endmodule

// [design/aeta_top.sv]
// Architected activity event type registers 0 to 2 and their read path.
// Assumes the pipeline presents one system-register access at a time and
// waits for req_ready; context inputs are synchronous to ref_clk.
`timescale 1ns/1ps
`include "aeta_defines.svh"
module aeta_top (
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // System-register request from the pipeline
  input  wire logic        req_valid,
  input  wire logic        req_write,
  input  wire logic [1:0]  req_op0,
  input  wire logic [2:0]  req_op1,
  input  wire logic [3:0]  req_crn,
  input  wire logic [3:0]  req_crm,
  input  wire logic [2:0]  req_op2,
  input  wire logic [1:0]  req_level,
  output logic             req_ready,
  // Execution context sampled with the request
  input  wire logic        halted,
  input  wire logic        secure_debug_disabled,
  input  wire logic        el2_enabled,
  input  wire logic        user_access_enable,
  input  wire logic        host_trap_general,
  input  wire logic        level2_monitor_trap,
  input  wire logic        level3_monitor_trap,
  // Answer to the pipeline
  output logic             rsp_valid,
  output logic             rsp_claimed,
  output logic             rsp_undefined,
  output logic             rsp_trap,
  output logic [1:0]       rsp_trap_level,
  output logic [5:0]       rsp_trap_class,
  output logic [63:0]      rsp_data,
  // External system-register view, low word only
  input  wire logic        ext_rd_valid,
  input  wire logic [1:0]  ext_rd_index,
  output logic             ext_rd_ack,
  output logic [31:0]      ext_rd_data,
  // Counter group 0 size as seen by software
  output logic [7:0]       group0_counter_number
);

  // Sequencer state
  aeta_pkg::aeta_state_t state;
  aeta_pkg::aeta_state_t next_state;

  // Captured request
  logic        cap_write;         // Access was a write
  logic        cap_group;         // Encoding hit the event type group
  logic [2:0]  cap_index;         // Register index from op2
  logic [1:0]  cap_level;         // Level of the access
  logic [6:0]  cap_ctx;           // Context bits, packed
  logic        next_cap_write;
  logic        next_cap_group;
  logic [2:0]  next_cap_index;
  logic [1:0]  next_cap_level;
  logic [6:0]  next_cap_ctx;

  // Answer registers
  logic        next_rsp_valid;
  logic        next_rsp_claimed;
  logic        next_rsp_undefined;
  logic        next_rsp_trap;
  logic [1:0]  next_rsp_trap_level;
  logic [5:0]  next_rsp_trap_class;
  logic [63:0] next_rsp_data;

  // External view registers
  logic        next_ext_rd_ack;
  logic [31:0] next_ext_rd_data;

  // Check results are combinational from the captured request and are
  // only consumed in the check cycle, where they are settled.
  // Register contents and check results
  logic [63:0] reg_value [3];     // Fixed event type registers
  logic        chk_undefined;     // Privilege check says undefined
  logic        chk_trap;          // Privilege check says trap
  logic [1:0]  chk_trap_level;    // Target level of the trap
  logic        group_hit;         // Live decode of the request
  logic        beyond_count;      // Index at or above the group 0 count
  logic        implemented;       // Index is one held here
  logic        claimed;           // This block answers the access

  // The numbers are held in flops rather than wired as constants, so a
  // later part with programmable events can reuse the same read path.
  // Reset loads them, which keeps the answer free of unknown bits.
  // The three registers, each with its own mandated event
  aeta_event_reg #(.EVENT(`AETA_EVT_0)) u_evt0 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .value   (reg_value[0])
  );
  aeta_event_reg #(.EVENT(`AETA_EVT_1)) u_evt1 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .value   (reg_value[1])
  );
  aeta_event_reg #(.EVENT(`AETA_EVT_2)) u_evt2 (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .value   (reg_value[2])
  );

  // Privilege checks on the captured access
  aeta_access_check u_check (
    .level                 (cap_level),
    .halted                (cap_ctx[0]),
    .secure_debug_disabled (cap_ctx[1]),
    .el2_enabled           (cap_ctx[2]),
    .user_access_enable    (cap_ctx[3]),
    .host_trap_general     (cap_ctx[4]),
    .level2_monitor_trap   (cap_ctx[5]),
    .level3_monitor_trap   (cap_ctx[6]),
    .undefined             (chk_undefined),
    .trap                  (chk_trap),
    .trap_level            (chk_trap_level)
  );

  // Software reads this size to learn how many architected counters exist;
  // the undefined-index check below uses the same constant so they agree.
  // Group count is fixed; it bounds the legal index range
  assign group0_counter_number = `AETA_CG0_COUNT;

  // One access in flight at a time keeps the captured context unambiguous.
  // The price is a spacing of three cycles between accepted accesses.
  // Only accept a new access when idle, so nothing is dropped
  assign req_ready = (state == aeta_pkg::AETA_IDLE);

  // Decoded on the live request so only one bit needs capturing;
  // op2 is kept whole because it also carries the out-of-range indices.
  // Encoding match on everything but op2
  assign group_hit = (req_op0 == `AETA_OP0) && (req_op1 == `AETA_OP1) &&
                     (req_crn == `AETA_CRN) && (req_crm == `AETA_CRM);

  // Indices 4 to 7 name counters that do not exist in group 0, so they
  // are answered here as undefined rather than left for another block.
  // Index classification of the captured access
  assign beyond_count = ({`AETA_IDX_PAD, cap_index} >= `AETA_CG0_COUNT);
  assign implemented  = (cap_index < `AETA_NUM_REGS);

  // Index 3 exists but lives in another block, so it is not claimed
  assign claimed = cap_group && (implemented || beyond_count);

  // Timing of one access, counted from the edge that takes it:
  //   after that edge  state is check, req_ready low
  //   after the next   state is answer, rsp_* stand for one cycle
  //   after the third  state is idle again and req_ready is high
  // The check cycle exists so the priority chain sees registered inputs.
  // Sequencer: take, check, answer, back to idle
  always_comb begin
    next_state = state;
    case (state)
      aeta_pkg::AETA_IDLE: begin
        // Wait for an access
        if (req_valid) begin
          next_state = aeta_pkg::AETA_CHECK;
        end
      end
      aeta_pkg::AETA_CHECK: begin
        // Checks settle from captured values
        next_state = aeta_pkg::AETA_RESP;
      end
      aeta_pkg::AETA_RESP: begin
        // Answer stands one cycle
        next_state = aeta_pkg::AETA_IDLE;
      end
      default: begin
        // Recover from an illegal code
        next_state = aeta_pkg::AETA_IDLE;
      end
    endcase
  end

  // State register; reset returns to idle
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state <= aeta_pkg::AETA_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Capture happens only on the taking edge; the registers then hold
  // steady until the next access, which lets the checks run from flops
  // and keeps a glitch on the context lines out of the answer.
  // Capture the access and its context together
  always_comb begin
    next_cap_write = cap_write;
    next_cap_group = cap_group;
    next_cap_index = cap_index;
    next_cap_level = cap_level;
    next_cap_ctx   = cap_ctx;
    if (req_valid && req_ready) begin
      // Context is frozen so a mid-access change cannot split the checks
      next_cap_write = req_write;
      next_cap_group = group_hit;
      next_cap_index = req_op2;
      next_cap_level = req_level;
      next_cap_ctx   = {level3_monitor_trap, level2_monitor_trap, host_trap_general,
                        user_access_enable, el2_enabled, secure_debug_disabled, halted};
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cap_write <= 1'b0;
      cap_group <= 1'b0;
      cap_index <= 3'h0;
      cap_level <= 2'h0;
      cap_ctx   <= 7'h00;
    end else begin
      cap_write <= next_cap_write;
      cap_group <= next_cap_group;
      cap_index <= next_cap_index;
      cap_level <= next_cap_level;
      cap_ctx   <= next_cap_ctx;
    end
  end

  // The answer is one flat priority chain: ownership, index range,
  // then the privilege outcome, then the data. Every field defaults to
  // zero so outputs read as zero outside the answer cycle.
  // Build the answer in the check cycle
  always_comb begin
    next_rsp_valid      = 1'b0;
    next_rsp_claimed    = 1'b0;
    next_rsp_undefined  = 1'b0;
    next_rsp_trap       = 1'b0;
    next_rsp_trap_level = 2'h0;
    next_rsp_trap_class = `AETA_NO_CLASS;
    next_rsp_data       = {`AETA_REG_W{1'b0}};
    if (state == aeta_pkg::AETA_CHECK) begin
      next_rsp_valid   = 1'b1;
      next_rsp_claimed = claimed;
      if (!claimed) begin
        // Not ours: pipeline asks another block
        next_rsp_claimed = 1'b0;
      end else if (beyond_count) begin
        // Counter absent: reads and writes alike
        next_rsp_undefined = 1'b1;
      end else if (chk_undefined) begin
        next_rsp_undefined = 1'b1;
      end else if (chk_trap) begin
        next_rsp_trap       = 1'b1;
        next_rsp_trap_level = chk_trap_level;
        next_rsp_trap_class = `AETA_TRAP_CLASS;
      end else if (cap_write) begin
        // Accepted but has no effect on the fixed numbers
        next_rsp_data = {`AETA_REG_W{1'b0}};
      end else begin
        // Permitted read returns the register
        next_rsp_data = reg_value[cap_index[1:0]];
      end
    end
  end

  // Answer flops; reset clears every field
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      rsp_valid      <= 1'b0;
      rsp_claimed    <= 1'b0;
      rsp_undefined  <= 1'b0;
      rsp_trap       <= 1'b0;
      rsp_trap_level <= 2'h0;
      rsp_trap_class <= `AETA_NO_CLASS;
      rsp_data       <= {`AETA_REG_W{1'b0}};
    end else begin
      rsp_valid      <= next_rsp_valid;
      rsp_claimed    <= next_rsp_claimed;
      rsp_undefined  <= next_rsp_undefined;
      rsp_trap       <= next_rsp_trap;
      rsp_trap_level <= next_rsp_trap_level;
      rsp_trap_class <= next_rsp_trap_class;
      rsp_data       <= next_rsp_data;
    end
  end

  // The external view answers every cycle it is asked, one cycle later.
  // It has no privilege checks; only the low word is visible there.
  // Index 3 is acknowledged with zero data so the requester never stalls.
  // External view: same low word, no privilege checks on this path
  always_comb begin
    next_ext_rd_ack  = ext_rd_valid;
    next_ext_rd_data = {`AETA_EXT_W{1'b0}};
    if (ext_rd_valid && ext_rd_index < `AETA_NUM_REGS) begin
      // Same source as the core view, so the two cannot diverge
      next_ext_rd_data = reg_value[ext_rd_index][`AETA_EXT_W-1:0];
    end
  end

  // External answer flops
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ext_rd_ack  <= 1'b0;
      ext_rd_data <= {`AETA_EXT_W{1'b0}};
    end else begin
      ext_rd_ack  <= next_ext_rd_ack;
      ext_rd_data <= next_ext_rd_data;
    end
  end

endmodule

// [tb/aeta_top_props.sv]
// Checker for the event type register bank, bound to aeta_top.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module aeta_props_chk (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Request side
  input wire logic        req_valid,
  input wire logic        req_ready,
  input wire logic [3:0]  req_crm,
  input wire logic [2:0]  req_op2,
  input wire logic [1:0]  req_level,
  input wire logic        halted,
  input wire logic        secure_debug_disabled,
  input wire logic        user_access_enable,
  input wire logic        level3_monitor_trap,
  // Answer side
  input wire logic        rsp_valid,
  input wire logic        rsp_undefined,
  input wire logic        rsp_trap,
  input wire logic [1:0]  rsp_trap_level,
  input wire logic [5:0]  rsp_trap_class,
  input wire logic [63:0] rsp_data,
  // External view and group size
  input wire logic        ext_rd_valid,
  input wire logic [1:0]  ext_rd_index,
  input wire logic        ext_rd_ack,
  input wire logic [31:0] ext_rd_data,
  input wire logic [7:0]  group0_counter_number
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  logic hit;   // Accepted request for one of our registers
  logic dbg;   // Halted with secure debug off and level-3 trap
  assign hit = req_valid && req_ready && req_crm == 4'h6 && req_op2 != 3'h3;
  assign dbg = halted && secure_debug_disabled && level3_monitor_trap;
  chk_answer_timing: assert property (req_valid && req_ready |=> !req_ready ##1
    (!req_ready && rsp_valid) ##1 (req_ready && !rsp_valid))
    else $error("answer not one cycle after check");
  chk_answer_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer longer than one cycle");
  chk_upper_zero: assert property (rsp_valid |-> rsp_data[63:16] == 48'h0)
    else $error("upper bits not zero");
  chk_data_idle: assert property (!rsp_valid |-> rsp_data == 64'h0)
    else $error("data outside answer");
  chk_trap_class: assert property (rsp_valid && rsp_trap |-> rsp_trap_class == 6'h18
    && rsp_trap_level != 2'h0 && !rsp_undefined) else $error("bad trap class");
  chk_high_undef: assert property (hit && req_op2[2] |-> ##2 rsp_valid && rsp_undefined
    && !rsp_trap) else $error("high index not undefined");
  chk_top_level: assert property (hit && !req_op2[2] && req_level == 2'h3
    |-> ##2 rsp_valid && !rsp_undefined && !rsp_trap) else $error("level 3 refused");
  chk_halt_undef: assert property (hit && req_level != 2'h3 && dbg
    |-> ##2 rsp_undefined && !rsp_trap) else $error("halted access not undefined");
  chk_user_trap: assert property (hit && !req_op2[2] && req_level == 2'h0 && !dbg
    && !user_access_enable |-> ##2 rsp_trap) else $error("user access not trapped");
  chk_ext_word: assert property (ext_rd_valid && ext_rd_index == 2'h1
    |=> ext_rd_ack && ext_rd_data == 32'h1004) else $error("external word wrong");
  chk_ext_idle: assert property (!ext_rd_valid |=> !ext_rd_ack && ext_rd_data == 32'h0)
    else $error("external ack without read");
  chk_group_count: assert property (group0_counter_number == 8'h04)
    else $error("group count not four");
endmodule

// [tb/aeta_pipe_model.sv]
// Pipeline model issuing system-register accesses one at a time.
// Assumes the bank takes a request on an edge where req_ready is high.
`timescale 1ns/1ps
module aeta_pipe_model (
  // Clock and handshake
  input  wire logic       ref_clk,
  input  wire logic       req_ready,
  // Request fields
  output logic            req_valid,
  output logic            req_write,
  output logic [1:0]      req_op0,
  output logic [2:0]      req_op1,
  output logic [3:0]      req_crn,
  output logic [3:0]      req_crm,
  output logic [2:0]      req_op2,
  output logic [1:0]      req_level,
  // Context held with the request
  output logic            halted,
  output logic            secure_debug_disabled,
  output logic            el2_enabled,
  output logic            user_access_enable,
  output logic            host_trap_general,
  output logic            level2_monitor_trap,
  output logic            level3_monitor_trap
);
  logic [18:0] fld;  // Encoding, level and direction
  logic [6:0]  ctx;  // Context bits
  assign {req_write, req_op0, req_op1, req_crn, req_crm, req_op2, req_level} = fld;
  assign {halted, secure_debug_disabled, el2_enabled, user_access_enable,
          host_trap_general, level2_monitor_trap, level3_monitor_trap} = ctx;
  // Quiet until the first access
  initial begin
    req_valid = 1'b0;
    fld = 19'h0;
    ctx = 7'h0;
  end
  // Held until taken; afterwards the lines show the inverse, not stale data
  task automatic issue(input logic w, input logic [3:0] crm, input logic [2:0] o,
                       input logic [1:0] lv, input logic [6:0] c);
    @(negedge ref_clk);
    req_valid = 1'b1;
    fld = {w, 2'h3, 3'h3, 4'hd, crm, o, lv};
    ctx = c;
    // Ready comes from a flop, so its mid-cycle value holds at the next edge
    while (req_ready !== 1'b1) @(negedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    req_valid = 1'b0;
    fld = ~fld;
    ctx = ~ctx;
  endtask
endmodule

// [tb/activity_event_type_access_test.sv]
// Self-checking bench for the event type register bank.
// Assumes the pipeline model and checker files are compiled first.
`timescale 1ns/1ps
module activity_event_type_access_test;
  logic        ref_clk, rst_n;                        // Clock, reset
  logic        req_valid, req_write, req_ready;       // Handshake
  logic [1:0]  req_op0, req_level, rsp_trap_level;    // Small fields
  logic [2:0]  req_op1, req_op2;                      // Op fields
  logic [3:0]  req_crn, req_crm;                      // Register fields
  logic        halted, secure_debug_disabled, el2_enabled, user_access_enable;
  logic        host_trap_general, level2_monitor_trap, level3_monitor_trap;
  logic        rsp_valid, rsp_claimed, rsp_undefined, rsp_trap;
  logic [5:0]  rsp_trap_class;                        // Trap class
  logic [63:0] rsp_data;                              // Read value
  logic        ext_rd_valid, ext_rd_ack;              // External view
  logic [1:0]  ext_rd_index;                          // External index
  logic [31:0] ext_rd_data;                           // External word
  logic [7:0]  group0_counter_number;                 // Group size
  int          error_cnt, tests_run;                  // Tallies
  logic [74:0] rsp_q[$];                              // Expected answers
  logic [31:0] ext_q[$];                              // Expected words

  aeta_top aeta_top_inst (.ref_clk, .rst_n, .req_valid, .req_write, .req_op0, .req_op1,
    .req_crn, .req_crm, .req_op2, .req_level, .req_ready, .halted, .secure_debug_disabled,
    .el2_enabled, .user_access_enable, .host_trap_general, .level2_monitor_trap,
    .level3_monitor_trap, .rsp_valid, .rsp_claimed, .rsp_undefined, .rsp_trap,
    .rsp_trap_level, .rsp_trap_class, .rsp_data, .ext_rd_valid, .ext_rd_index,
    .ext_rd_ack, .ext_rd_data, .group0_counter_number);
  aeta_pipe_model aeta_pipe_model_inst (.ref_clk, .req_ready, .req_valid, .req_write,
    .req_op0, .req_op1, .req_crn, .req_crm, .req_op2, .req_level, .halted,
    .secure_debug_disabled, .el2_enabled, .user_access_enable, .host_trap_general,
    .level2_monitor_trap, .level3_monitor_trap);

  // Free-running core clock
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // One comparison, four-state exact
  task chk(input logic [74:0] seen, input logic [74:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Verdict and end of run
  task wrap_up;
    $display("errors %0d checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Claimed, undefined, trap, level, class, data; checks in priority order
  function automatic logic [74:0] expect_rsp(logic w, logic [3:0] crm, logic [2:0] o,
                                             logic [1:0] lv, logic [6:0] c);
    logic h, s, e2, ue, tg, t2, t3;
    logic [15:0] ev;
    {h, s, e2, ue, tg, t2, t3} = c;
    ev = (o == 3'h0) ? 16'h0011 : (o == 3'h1) ? 16'h1004 : 16'h0000;
    if (crm != 4'h6 || o == 3'h3) return 75'h0;
    if (o[2]) return {3'b110, 72'h0};
    if (lv != 2'h3) begin
      if (h && s && t3) return {3'b110, 72'h0};
      if (lv == 2'h0 && !ue) return {3'b101, (e2 && tg) ? 2'h2 : 2'h1, 6'h18, 64'h0};
      if (lv != 2'h2 && e2 && t2) return {3'b101, 2'h2, 6'h18, 64'h0};
      if (t3) return {3'b101, 2'h3, 6'h18, 64'h0};
    end
    return {3'b100, 8'h0, w ? 64'h0 : {48'h0, ev}};
  endfunction

  // Note the answer, then hand the access to the pipeline model
  task automatic send(input logic w, input logic [3:0] crm, input logic [2:0] o,
                      input logic [1:0] lv, input logic [6:0] c);
    rsp_q.push_back(expect_rsp(w, crm, o, lv, c));
    aeta_pipe_model_inst.issue(w, crm, o, lv, c);
  endtask

  // Results are looked at mid-cycle, where they are settled
  always @(negedge ref_clk) begin
    if (rsp_valid === 1'b1)
      chk({rsp_claimed, rsp_undefined, rsp_trap, rsp_trap_level, rsp_trap_class, rsp_data},
          rsp_q.size() ? rsp_q.pop_front() : 75'h1);
    if (ext_rd_ack === 1'b1)
      chk({43'h0, ext_rd_data}, {43'h0, ext_q.size() ? ext_q.pop_front() : 32'h1});
  end

  // Main sequence
  initial begin
    int k;
    int s;
    error_cnt = 0;
    tests_run = 0;
    rst_n = 1'b0;
    ext_rd_valid = 1'b0;
    ext_rd_index = 2'h0;
    s = $urandom(32'h8548);
    repeat (20) @(negedge ref_clk);
    rst_n = 1'b1;
    chk({66'h0, group0_counter_number, req_ready}, {66'h0, 8'h04, 1'b1});
    for (k = 0; k < 3; k++) send(1'b0, 4'h6, k[2:0], 2'h3, 7'h7f);
    send(1'b1, 4'h6, 3'h1, 2'h3, 7'h00);
    send(1'b0, 4'h6, 3'h1, 2'h3, 7'h00);
    send(1'b0, 4'h2, 3'h0, 2'h3, 7'h00);
    // Random levels, indices and context, some writes
    repeat (150) send(3'($urandom()) == 3'h0, 4'h6, 3'($urandom()), 2'($urandom()),
                      7'($urandom()));
    // Back-to-back external reads
    repeat (16) begin
      @(negedge ref_clk);
      ext_rd_valid = 1'b1;
      ext_rd_index = 2'($urandom());
      ext_q.push_back(ext_rd_index == 2'h0 ? 32'h11 : ext_rd_index == 2'h1 ? 32'h1004 : 32'h0);
    end
    @(negedge ref_clk);
    ext_rd_valid = 1'b0;
    ext_rd_index = ~ext_rd_index;
    repeat (10) @(negedge ref_clk);
    chk(75'(rsp_q.size() + ext_q.size()), 75'h0);
    wrap_up;
  end

  // Cut a hang short
  initial begin
    #400000;
    error_cnt++;
    wrap_up;
  end
endmodule

bind aeta_top aeta_props_chk aeta_props_chk_inst (.ref_clk, .rst_n, .req_valid, .req_ready,
  .req_crm, .req_op2, .req_level, .halted, .secure_debug_disabled, .user_access_enable,
  .level3_monitor_trap, .rsp_valid, .rsp_undefined, .rsp_trap, .rsp_trap_level,
  .rsp_trap_class, .rsp_data, .ext_rd_valid, .ext_rd_index, .ext_rd_ack, .ext_rd_data,
  .group0_counter_number);
